/* File: core/stc_consts.vh */
// stc_consts.vh: offsets, field positions, reset values and command codes
// for the split timer control block; included by the design file only.
// Overview of operation
// - high enable routes high channel to output n+3 in waveform mode
// - low enable routes low channel to output n in waveform mode
// - stopped: high value bit drives output n+3
// - stopped: low value bit drives output n
// - pad output needs matching enable bit set
// - logic block output bypasses enable bits
// - split select bit 0 picks split operation
// - clear view clears bits written one
// - set view sets bits written one
// - command field always reads zero
// - command restart or hard reset, reset needs stopped
// - command target three selects both counters
// - bits four to six enable compare interrupts
// - bit one enables high underflow interrupt
// - bit zero enables low underflow interrupt
// - low compare match sets its flag always
// - compare flags clear only on written one
// - high underflow sets flag bit one
// - low underflow sets flag bit zero
// - control A bit zero starts and stops
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH
`define STC_OFS_CTRL_A     8'h00
`define STC_OFS_OUT_EN     8'h01
`define STC_OFS_OUT_VAL    8'h02
`define STC_OFS_SPLIT      8'h03
`define STC_OFS_CMD_CLR    8'h04
`define STC_OFS_CMD_SET    8'h05
`define STC_OFS_INT_EN     8'h0A
`define STC_OFS_INT_FLAG   8'h0B
`define STC_MASK_CHAN      8'h77
`define STC_MASK_INT       8'h73
`define STC_MASK_TARGET    8'h03
`define STC_MASK_CTRL_A    8'h0F
`define STC_RST_ZERO       8'h00
`define STC_CMD_RESTART    2'h2
`define STC_CMD_HARD_RESET 2'h3
`define STC_TARGET_BOTH    2'h3
`define STC_BIT_ENABLE     0
`define STC_BIT_SPLIT      0
`define STC_BIT_LOW_UNDERFLOW       0
`define STC_BIT_HIGH_UNDERFLOW       1
`define STC_BIT_LMATCH0    4
`endif

/* File: core/stc_split_timer_ctrl.v */
// stc_split_timer_ctrl.v: control, command and flag logic of the split timer.
// assumes a byte register port synchronous to core_clk_i; counter events and
// waveform generator levels come from the counting core outside.
`include "stc_consts.vh"
`default_nettype none
module stc_split_timer_ctrl #(
  parameter N_CHAN = 3
) (
  input  wire               core_clk_i,
  input  wire               reset_i,
  input  wire               clk_en_i,
  input  wire               reg_wr_i,
  input  wire               reg_rd_i,
  input  wire [7:0]         reg_addr_i,
  input  wire [7:0]         reg_wdata_i,
  output reg  [7:0]         reg_rdata_o,
  input  wire               wave_mode_i,
  input  wire [N_CHAN-1:0]  low_wave_i,
  input  wire [N_CHAN-1:0]  high_wave_i,
  input  wire [N_CHAN-1:0]  low_channel_match_i,
  input  wire               low_underflow_i,
  input  wire               high_underflow_i,
  input  wire [5:0]         port_out_i,
  input  wire               to_logic_block_i,
  output reg  [5:0]         waveform_output_o,
  output reg                timer_enable_o,
  output reg                split_operation_select_o,
  output reg  [1:0]         command_target_o,
  output reg                restart_pulse_o,
  output reg                hard_reset_pulse_o,
  output reg  [7:0]         int_pending_o
);
  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  reg  [7:0] ctrl_a_r;
  reg  [7:0] out_en_r;
  reg  [7:0] out_val_r;
  reg  [7:0] split_r;
  reg  [7:0] target_r;
  reg  [7:0] int_en_r;
  reg  [7:0] flag_r;
  reg  [7:0] flag_nxt;
  reg  [7:0] flag_set;
  reg  [7:0] flag_clr;
  wire [5:0] wave_nxt;
  wire [5:0] chan_enable;
  wire [5:0] chan_value;
  wire [5:0] chan_wave;
  reg  [7:0] rdata_nxt;
  reg        restart_nxt;
  reg        hard_reset_nxt;
  wire       wr_ctrl_a;
  wire       wr_out_en;
  wire       wr_out_val;
  wire       wr_split;
  wire       wr_int_en;
  wire       wr_flag;
  reg  [1:0] cmd_w;
  reg  [1:0] tgt_w;
  wire       running;
  wire       wr_set;
  wire       wr_clr;

  assign running = ctrl_a_r[`STC_BIT_ENABLE];
  assign wr_set  = reg_wr_i && (reg_addr_i == `STC_OFS_CMD_SET);
  assign wr_clr  = reg_wr_i && (reg_addr_i == `STC_OFS_CMD_CLR);

  // --------------------------------------------------------------------
  // decoded register write selects
  // --------------------------------------------------------------------
  assign wr_ctrl_a  = reg_wr_i && (reg_addr_i == `STC_OFS_CTRL_A);
  assign wr_out_en  = reg_wr_i && (reg_addr_i == `STC_OFS_OUT_EN);
  assign wr_out_val = reg_wr_i && (reg_addr_i == `STC_OFS_OUT_VAL);
  assign wr_split   = reg_wr_i && (reg_addr_i == `STC_OFS_SPLIT);
  assign wr_int_en  = reg_wr_i && (reg_addr_i == `STC_OFS_INT_EN);
  assign wr_flag    = reg_wr_i && (reg_addr_i == `STC_OFS_INT_FLAG);

  // --------------------------------------------------------------------
  // flag update: set wins over clear
  // --------------------------------------------------------------------
  always @*
  begin
    flag_set = 8'h00;
    flag_set[`STC_BIT_LMATCH0 +: 3] = low_channel_match_i;
    flag_set[`STC_BIT_HIGH_UNDERFLOW] = high_underflow_i;
    flag_set[`STC_BIT_LOW_UNDERFLOW] = low_underflow_i;
    flag_clr = 8'h00;
    if (wr_flag)
      flag_clr = reg_wdata_i;
    flag_nxt = ((flag_r & ~flag_clr) | flag_set) & `STC_MASK_INT;
  end

  // --------------------------------------------------------------------
  // command decode from the set view
  // --------------------------------------------------------------------
  always @*
  begin
    cmd_w          = reg_wdata_i[3:2];
    tgt_w          = target_r[1:0] | reg_wdata_i[1:0];
    restart_nxt    = 1'b0;
    hard_reset_nxt = 1'b0;
    // command field is acted on, never stored
    if (wr_set && (tgt_w == `STC_TARGET_BOTH))
    begin
      case (cmd_w)
        `STC_CMD_RESTART:    restart_nxt = 1'b1;
        `STC_CMD_HARD_RESET: hard_reset_nxt = ~running;
        default:
        begin
          restart_nxt    = 1'b0;
          hard_reset_nxt = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // control A: only the enable bit acts here
  // --------------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
      ctrl_a_r <= `STC_RST_ZERO;
    else if (clk_en_i && wr_ctrl_a)
      ctrl_a_r <= reg_wdata_i & `STC_MASK_CTRL_A;
  end

  // --------------------------------------------------------------------
  // output enable bits
  // --------------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
      out_en_r <= `STC_RST_ZERO;
    else if (clk_en_i && wr_out_en)
      out_en_r <= reg_wdata_i & `STC_MASK_CHAN;
  end

  // --------------------------------------------------------------------
  // output value bits, used while stopped
  // --------------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
      out_val_r <= `STC_RST_ZERO;
    else if (clk_en_i && wr_out_val)
      out_val_r <= reg_wdata_i & `STC_MASK_CHAN;
  end

  // --------------------------------------------------------------------
  // split select, bit 0 only
  // --------------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
      split_r <= `STC_RST_ZERO;
    else if (clk_en_i && wr_split)
      split_r <= reg_wdata_i & 8'h01;
  end

  // --------------------------------------------------------------------
  // interrupt enables
  // --------------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
      int_en_r <= `STC_RST_ZERO;
    else if (clk_en_i && wr_int_en)
      int_en_r <= reg_wdata_i & `STC_MASK_INT;
  end

  // --------------------------------------------------------------------
  // command target through the set and clear views
  // --------------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
      target_r <= `STC_RST_ZERO;
    else if (clk_en_i && wr_clr)
      target_r <= target_r & ~(reg_wdata_i & `STC_MASK_TARGET);
    else if (clk_en_i && wr_set)
      target_r <= (target_r | reg_wdata_i) & `STC_MASK_TARGET;
  end

  // --------------------------------------------------------------------
  // interrupt flags
  // --------------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
      flag_r <= `STC_RST_ZERO;
    else if (clk_en_i)
      flag_r <= flag_nxt;
  end

  // --------------------------------------------------------------------
  // command pulses, one cycle each
  // --------------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      restart_pulse_o    <= 1'b0;
      hard_reset_pulse_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      restart_pulse_o    <= restart_nxt;
      hard_reset_pulse_o <= hard_reset_nxt;
    end
  end

  // --------------------------------------------------------------------
  // waveform output routing, one slice per output
  // --------------------------------------------------------------------
  assign chan_enable = {out_en_r[6:4], out_en_r[2:0]};
  assign chan_value  = {out_val_r[6:4], out_val_r[2:0]};
  assign chan_wave   = {high_wave_i, low_wave_i};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_route
      wire lvl;
      wire pad_take;
      // stopped timer shows the stored output value
      assign lvl      = running ? chan_wave[gi] : chan_value[gi];
      // pad path: enable bit only counts in waveform mode
      assign pad_take = wave_mode_i & chan_enable[gi];
      // logic block path ignores the enable bits
      assign wave_nxt[gi] = (to_logic_block_i | pad_take) ? lvl : port_out_i[gi];
    end
  endgenerate

  // --------------------------------------------------------------------
  // read data select
  // --------------------------------------------------------------------
  always @*
  begin
    case (reg_addr_i)
      `STC_OFS_CTRL_A:   rdata_nxt = ctrl_a_r;
      `STC_OFS_OUT_EN:   rdata_nxt = out_en_r;
      `STC_OFS_OUT_VAL:  rdata_nxt = out_val_r;
      `STC_OFS_SPLIT:    rdata_nxt = split_r;
      `STC_OFS_CMD_CLR:  rdata_nxt = target_r;
      `STC_OFS_CMD_SET:  rdata_nxt = target_r;
      `STC_OFS_INT_EN:   rdata_nxt = int_en_r;
      `STC_OFS_INT_FLAG: rdata_nxt = flag_r;
      default:           rdata_nxt = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // registered outputs and read data
  // --------------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      waveform_output_o        <= 6'h00;
      timer_enable_o           <= 1'b0;
      split_operation_select_o <= 1'b0;
      command_target_o         <= 2'h0;
      int_pending_o            <= 8'h00;
      reg_rdata_o              <= 8'h00;
    end
    else if (clk_en_i)
    begin
      waveform_output_o        <= wave_nxt;
      timer_enable_o           <= running;
      split_operation_select_o <= split_r[`STC_BIT_SPLIT];
      command_target_o         <= target_r[1:0];
      int_pending_o            <= flag_r & int_en_r;
      // read data holds until the next read
      if (reg_rd_i)
        reg_rdata_o <= rdata_nxt;
    end
  end
endmodule // stc_split_timer_ctrl
`default_nettype wire

/* File: verification/stc_split_timer_ctrl_asserts.sv */
// stc_split_timer_ctrl_asserts.sv: port checks of the split timer control block
// assumes the bind below and the single core_clk_i domain
`default_nettype none
module stc_ctrl_asserts (
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic       clk_en_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       timer_enable_o,
  input wire logic [1:0] command_target_o,
  input wire logic       restart_pulse_o,
  input wire logic       hard_reset_pulse_o,
  input wire logic [7:0] int_pending_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  wire  int_wr = reg_wr_i && reg_addr_i[7:1] == 7'h05;
  logic int_wr_r;
  always @(posedge core_clk_i) int_wr_r <= int_wr;
  sequence s_cmd(logic [1:0] c);
    clk_en_i && reg_wr_i && reg_addr_i == 8'h05 && reg_wdata_i[3:2] == c;
  endsequence
  a_restart_fires: assert property (s_cmd(2'h2) ##0 reg_wdata_i[1:0] == 2'h3 |=> restart_pulse_o)
    else $error("restart command gave no pulse");
  a_reset_ignored: assert property (s_cmd(2'h3) ##0 timer_enable_o |=> !hard_reset_pulse_o)
    else $error("hard reset taken while running");
  a_no_target: assert property (s_cmd(2'h2) ##0 (reg_wdata_i[1:0] != 2'h3 && command_target_o != 2'h3) |=> !restart_pulse_o)
    else $error("command fired without target");
  a_enable_copy: assert property (clk_en_i && reg_wr_i && reg_addr_i == 8'h00 ##1 clk_en_i |=> timer_enable_o == $past(reg_wdata_i[0], 2))
    else $error("enable bit not taken");
  a_flag_sticky: assert property (!int_wr && !int_wr_r |=> (int_pending_o & $past(int_pending_o)) == $past(int_pending_o))
    else $error("pending bit dropped without write");
  a_no_high_irq: assert property (int_pending_o[7] == 1'b0 && int_pending_o[3:2] == 2'h0)
    else $error("reserved pending bit set");
  a_unmapped_zero: assert property (clk_en_i && reg_rd_i && reg_addr_i inside {[8'h06:8'h09], [8'h0C:8'hFF]} |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_cmd_reads_zero: assert property (clk_en_i && reg_rd_i && reg_addr_i[7:1] == 7'h02 |=> reg_rdata_o[3:2] == 2'h0)
    else $error("command field read non-zero");
endmodule // stc_ctrl_asserts
bind stc_split_timer_ctrl stc_ctrl_asserts u_chk (.core_clk_i, .reset_i, .clk_en_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .timer_enable_o, .command_target_o,
  .restart_pulse_o, .hard_reset_pulse_o, .int_pending_o);
`default_nettype wire

/* File: verification/stc_split_timer_ctrl_tb.sv */
// stc_split_timer_ctrl_tb.sv: self-checking random bench of the split timer control
// assumes the design and its bound checker are compiled before it
`default_nettype none
module stc_split_timer_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_i = '0, reset_i = '1, clk_en_i = '1, reg_wr_i = '0, reg_rd_i = '0;
  logic [7:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o, int_pending_o, en, ov, d, e;
  logic       wave_mode_i = '0, to_logic_block_i = '0, low_underflow_i = '0, high_underflow_i = '0;
  logic [2:0] low_wave_i = '0, high_wave_i = '0, low_channel_match_i = '0;
  logic [5:0] port_out_i = '0, waveform_output_o;
  logic       timer_enable_o, split_operation_select_o, restart_pulse_o, hard_reset_pulse_o;
  logic [1:0] command_target_o, p;
  logic [7:0] offs [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h0A, 8'h0B, 8'h0C};
  int         fails = 0, checks_done = 0;
  stc_split_timer_ctrl u_dut (.core_clk_i, .reset_i, .clk_en_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .wave_mode_i, .low_wave_i, .high_wave_i,
    .low_channel_match_i, .low_underflow_i, .high_underflow_i, .port_out_i, .to_logic_block_i,
    .waveform_output_o, .timer_enable_o, .split_operation_select_o, .command_target_o,
    .restart_pulse_o, .hard_reset_pulse_o, .int_pending_o);
  initial forever #20 core_clk_i = ~core_clk_i;
  task automatic tick;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write, then keep the pulses seen in the following cycle
  task automatic wr(input logic [7:0] a, dat);
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, dat};
    tick();
    reg_wr_i = 1'b0;
    p = {restart_pulse_o, hard_reset_pulse_o};
    tick();
  endtask
  task automatic rd(input logic [7:0] a, exp);
    {reg_rd_i, reg_addr_i} = {1'b1, a};
    tick();
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
    tick();
  endtask
  function automatic logic [5:0] wexp(input logic [7:0] e, v, input logic [5:0] w, o,
                                      input logic run, lb, md);
    logic [5:0] s;
    s = run ? w : {v[6:4], v[2:0]};
    return lb ? s : md ? (s & {e[6:4], e[2:0]}) | (o & ~{e[6:4], e[2:0]}) : o;
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #400000;
    fails++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(32'h3481B5F2));
    repeat (5) tick();
    reset_i = 1'b0;
    foreach (offs[i]) rd(offs[i], 8'h00);
    wr(8'h05, 8'h09);
    chk(8'(p), 8'h00);
    rd(8'h05, 8'h01);
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h00);
    wr(8'h05, 8'h03);
    rd(8'h04, 8'h03);
    wr(8'h00, 8'h01);
    chk(8'(timer_enable_o), 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h05, {4'h0, 2'(c), 2'h3});
      chk(8'(p), {6'h00, c == 2, 1'b0});
    end
    wr(8'h00, 8'h00);
    wr(8'h05, 8'h0F);
    chk(8'(p), 8'h01);
    repeat (12)
    begin
      d = 8'($urandom);
      e = 8'($urandom);
      wr(8'h02, d);
      rd(8'h02, d & 8'h77);
      wr(8'h03, d);
      rd(8'h03, d & 8'h01);
      chk(8'(split_operation_select_o), 8'(d[0]));
      wr(8'h0A, e);
      rd(8'h0A, e & 8'h73);
      d = d & 8'h73;
      {low_channel_match_i, high_underflow_i, low_underflow_i} = {d[6:4], d[1:0]};
      tick();
      {low_channel_match_i, high_underflow_i, low_underflow_i} = '0;
      rd(8'h0B, d);
      wr(8'h0B, ~d);
      rd(8'h0B, d);
      chk(int_pending_o, d & e);
      wr(8'h0B, 8'hFF);
      rd(8'h0B, 8'h00);
    end
    // event and write-one clear in one cycle: the event wins
    {reg_wr_i, reg_addr_i, reg_wdata_i, low_underflow_i} = {1'b1, 8'h0B, 8'h01, 1'b1};
    tick();
    {reg_wr_i, low_underflow_i} = '0;
    rd(8'h0B, 8'h01);
    wr(8'h0B, 8'h01);
    rd(8'h0B, 8'h00);
    clk_en_i = 1'b0;
    wr(8'h0A, ~e);
    clk_en_i = 1'b1;
    rd(8'h0A, e & 8'h73);
    reset_i = 1'b1;
    tick();
    reset_i = 1'b0;
    rd(8'h0A, 8'h00);
    repeat (24)
    begin
      en = 8'($urandom);
      ov = 8'($urandom);
      d = 8'($urandom);
      wave_mode_i = en[7];
      wr(8'h01, en);
      wr(8'h02, ov);
      wr(8'h00, {7'h00, d[7]});
      {high_wave_i, low_wave_i, to_logic_block_i} = {d[5:0], d[6]};
      port_out_i = 6'($urandom);
      tick();
      tick();
      chk(8'(waveform_output_o), 8'(wexp(en, ov, d[5:0], port_out_i, d[7], d[6], en[7])));
    end
    wrap_up();
  end
endmodule // stc_split_timer_ctrl_tb
`default_nettype wire
